// ---- dsp_top.sv ----
// dual-slope waveform timer core with two fault/capture event inputs
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/10ps
// Notes on behaviour
// RULE1: counter runs bottom-clear down to zero and back up, one cycle per sweep.
// RULE2: output A sets on down-count A-set match, clears on up-count match.
// RULE3: output B sets on up-count B-set match, clears on down-count match.
// RULE4: the A-clear compare is stored but never steers the waveform.
// RULE5: start loads bottom-clear and counts down; B stays low until up-match.
// RULE6: disable-at-end-of-cycle strobe stops the timer when the cycle completes.
// RULE7: clearing enable stops the timer at once.
// RULE8: each input acts only when its trigger-enable bit is set.
// RULE9: inputs default to fault detection, action bit makes them capture triggers.
// RULE10: both inputs share fault modes; blanking only masks input A.
// RULE11: synced events override outputs after two to three clocks; async at once.
// RULE12: chosen output edge starts blank counter; A masked until delay value.
// RULE13: delay clock is the clock divided by the prescaler factor.
// RULE14: software must not combine blanking with the delayed output event.
// RULE15: with filter set, pulses under four clocks are dropped.
// RULE16: async detection overrides outputs raw; sequencing waits for sync level.
// RULE17: software must not set async detection and filter together.
// RULE18: sync strobe copies compares now; cycle-end strobe copies at cycle end.
// RULE19: restart strobe restarts counter; capture strobes copy count to A or B.
// RULE20: in dual-slope only fault modes 0, 4 and 7 are used.
// RULE21: a sync command during a pending sync is ignored.
// RULE22: fault mode 0 leaves outputs alone; captures still work.
// RULE23: fault mode 4 forces both outputs low while the event lasts.
// RULE24: fault mode 7 halts outputs and counter until restart, halting again if active.
// RULE25: command strobes pass a handshake stage and act at most once.
module dsp_top
   import dsp_pkg::*;
#(
   parameter int W = 16
)(
   input  wire logic                   SYS_CLK_I,
   input  wire logic                   RST_N_I,
   input  wire logic [dsp_pkg::AW-1:0] ADDR_I,
   input  wire logic [dsp_pkg::DW-1:0] WDATA_I,
   input  wire logic                   WR_I,
   input  wire logic                   RD_I,
   output logic      [dsp_pkg::DW-1:0] RDATA_O,
   input  wire logic                   EVENT_A_I,
   input  wire logic                   EVENT_B_I,
   output logic                        WAVE_OUT_A_O,
   output logic                        WAVE_OUT_B_O
);
   import dsp_pkg::*;

   typedef struct packed {
      logic              en;
      logic [W-1:0]      aset_b;
      logic [W-1:0]      aclr_b;
      logic [W-1:0]      bset_b;
      logic [W-1:0]      bclr_b;
      logic [W-1:0]      aset;
      logic [W-1:0]      bset;
      logic [W-1:0]      bclr;
      logic [7:0]        eva;
      logic [7:0]        evb;
      logic [5:0]        blk;
      logic [7:0]        bval;
      logic [CMD_W-1:0]  cmd;
      logic              sync_now;
      logic              sync_eoc;
      logic              dis_eoc;
      dsp_state_t        st;
      logic [W-1:0]      cnt;
      logic              out_a;
      logic              out_b;
      logic [W-1:0]      cap_a;
      logic [W-1:0]      cap_b;
      logic [2:0]        pre;
      logic [7:0]        bcnt;
      logic              brun;
      logic              lvl_a_q;
      logic              lvl_b_q;
      logic [DW-1:0]     rdata;
   } dsp_core_t;

   dsp_core_t s;
   dsp_core_t next_s;

   dsp_ev_if ev_a ();
   dsp_ev_if ev_b ();

   // event inputs come from outside the clock domain
   assign ev_a.raw     = EVENT_A_I;
   assign ev_a.filt_en = s.eva[EV_FILT];
   assign ev_b.raw     = EVENT_B_I;
   assign ev_b.filt_en = s.evb[EV_FILT];

   dsp_ev_cond u_cond_a (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .ev      (ev_a.cond)
   );

   dsp_ev_cond u_cond_b (
      .clk_i   (SYS_CLK_I),
      .rst_n_i (RST_N_I),
      .ev      (ev_b.cond)
   );

   // decoded event controls
   logic       busy;
   logic       blank_on;
   logic       mask_a;
   logic [3:0] mode_a;
   logic [3:0] mode_b;
   logic       flt_a;
   logic       flt_b;
   logic       capev_a;
   logic       capev_b;
   logic       kill_sync;
   logic       kill_async;
   logic       halt_req;

   assign busy     = s.sync_now | s.sync_eoc;
   assign blank_on = (s.blk[BLK_SEL +: 2] == BLK_SEL_ON);
   assign mask_a   = blank_on & s.brun; // RULE10
   assign mode_a   = s.eva[EV_MODE +: 4];
   assign mode_b   = s.evb[EV_MODE +: 4];

   // fault requests need trigger enable and fault (not capture) action
   assign flt_a = s.eva[EV_TRIG] & ~s.eva[EV_ACT] & ev_a.level & ~mask_a; // RULE8 RULE9 RULE12
   assign flt_b = s.evb[EV_TRIG] & ~s.evb[EV_ACT] & ev_b.level; // RULE8 RULE9

   // capture triggers fire on the rising edge of the conditioned level
   assign capev_a = s.eva[EV_TRIG] & s.eva[EV_ACT] & ev_a.level & ~s.lvl_a_q; // RULE9
   assign capev_b = s.evb[EV_TRIG] & s.evb[EV_ACT] & ev_b.level & ~s.lvl_b_q; // RULE9

   // mode 4 kills both outputs while active; mode 0 and others do nothing here
   assign kill_sync = (flt_a & (mode_a == FM_KILL)) | (flt_b & (mode_b == FM_KILL)); // RULE22 RULE23
   assign halt_req  = (flt_a & (mode_a == FM_WAIT)) | (flt_b & (mode_b == FM_WAIT)); // RULE24

   // raw-pin override bypasses the synchroniser; counter still waits for sync
   always_comb begin
      kill_async = 1'b0;
      if (s.eva[EV_ASYNC] && s.eva[EV_TRIG] && !s.eva[EV_ACT] && !mask_a
          && (mode_a == FM_KILL || mode_a == FM_WAIT)) begin
         kill_async = kill_async | EVENT_A_I; // RULE16
      end
      if (s.evb[EV_ASYNC] && s.evb[EV_TRIG] && !s.evb[EV_ACT]
          && (mode_b == FM_KILL || mode_b == FM_WAIT)) begin
         kill_async = kill_async | EVENT_B_I; // RULE16
      end
   end

   // whole core: register port, commands, sequencer, blanking
   always_comb begin
      logic           eoc;
      logic           rise;
      logic [2:0]     div_m1;
      logic [DW-1:0]  rv;
      eoc    = 1'b0;
      rise   = 1'b0;
      div_m1 = 3'h0;
      rv     = '0;
      next_s = s;
      next_s.cmd     = '0;
      next_s.lvl_a_q = ev_a.level;
      next_s.lvl_b_q = ev_b.level;

      // register writes; double buffers refuse writes while a copy is pending
      if (WR_I) begin
         case (ADDR_I)
            REG_CTRL: begin
               next_s.en = WDATA_I[0];
            end
            REG_CMD: begin
               next_s.cmd = WDATA_I[CMD_W-1:0]; // RULE25
            end
            REG_ASET: begin
               if (!busy) next_s.aset_b = WDATA_I[W-1:0];
            end
            REG_ACLR: begin
               if (!busy) next_s.aclr_b = WDATA_I[W-1:0]; // RULE4
            end
            REG_BSET: begin
               if (!busy) next_s.bset_b = WDATA_I[W-1:0];
            end
            REG_BCLR: begin
               if (!busy) next_s.bclr_b = WDATA_I[W-1:0];
            end
            REG_EVA: begin
               next_s.eva = WDATA_I[7:0];
            end
            REG_EVB: begin
               next_s.evb = WDATA_I[7:0];
            end
            REG_BLK: begin
               next_s.blk = WDATA_I[5:0];
            end
            REG_BVAL: begin
               next_s.bval = WDATA_I[7:0];
            end
            default: begin
            end
         endcase
      end

      // strobes held one cycle in the handshake stage, then consumed once
      if (s.st != ST_IDLE) begin
         if (s.cmd[CMD_SYNC] && !busy) next_s.sync_now = 1'b1; // RULE18 RULE21
         if (s.cmd[CMD_SEOC] && !busy) next_s.sync_eoc = 1'b1; // RULE18 RULE21
         if (s.cmd[CMD_DEOC]) next_s.dis_eoc = 1'b1; // RULE6
      end
      if (s.cmd[CMD_CAPA] || capev_a) next_s.cap_a = s.cnt; // RULE19
      if (s.cmd[CMD_CAPB] || capev_b) next_s.cap_b = s.cnt; // RULE19

      // immediate copy of the double-buffered compares
      if (s.sync_now) begin
         next_s.aset     = s.aset_b; // RULE18
         next_s.bset     = s.bset_b;
         next_s.bclr     = s.bclr_b;
         next_s.sync_now = 1'b0;
      end

      // counter sequencer
      case (s.st)
         ST_IDLE: begin
            next_s.out_a = 1'b0;
            next_s.out_b = 1'b0;
            if (s.en) begin
               next_s.aset = s.aset_b; // RULE5
               next_s.bset = s.bset_b;
               next_s.bclr = s.bclr_b;
               next_s.cnt  = s.bclr_b;
               next_s.st   = ST_DOWN;
            end
         end
         ST_DOWN: begin
            if (s.cnt == s.aset) next_s.out_a = 1'b1; // RULE2
            if (s.cnt == s.bset) next_s.out_b = 1'b0; // RULE3
            if (s.cnt == '0) begin
               next_s.st = ST_UP; // RULE1
            end else begin
               next_s.cnt = s.cnt - 1'b1;
            end
         end
         ST_UP: begin
            if (s.cnt == s.aset) next_s.out_a = 1'b0; // RULE2
            if (s.cnt == s.bset) next_s.out_b = 1'b1; // RULE3 RULE5
            if (s.cnt >= s.bclr) begin
               eoc       = 1'b1;
               next_s.st = ST_DOWN; // RULE1
               next_s.cnt = s.bclr;
            end else begin
               next_s.cnt = s.cnt + 1'b1;
            end
         end
         ST_HALT: begin
            next_s.out_a = 1'b0;
            next_s.out_b = 1'b0;
         end
         default: begin
            next_s.st = ST_IDLE;
         end
      endcase

      // end-of-cycle actions: deferred copy and deferred disable
      if (eoc) begin
         if (s.sync_eoc) begin
            next_s.aset     = s.aset_b; // RULE18
            next_s.bset     = s.bset_b;
            next_s.bclr     = s.bclr_b;
            next_s.cnt      = s.bclr_b;
            next_s.sync_eoc = 1'b0;
         end
         if (s.dis_eoc) begin
            next_s.st      = ST_IDLE; // RULE6
            if (!(WR_I && ADDR_I == REG_CTRL)) next_s.en = 1'b0; // a software write in this cycle wins
            next_s.dis_eoc = 1'b0;
         end
      end

      // restart puts the counter back at the start of a cycle
      if (s.cmd[CMD_RST] && s.st != ST_IDLE) begin
         next_s.st    = ST_DOWN; // RULE19
         next_s.cnt   = s.bclr;
         next_s.out_a = 1'b0;
         next_s.out_b = 1'b0;
      end

      // mode 7 halt; an event still present after restart halts again
      if (halt_req && s.st != ST_IDLE) begin
         next_s.st    = ST_HALT; // RULE24
         next_s.out_a = 1'b0;
         next_s.out_b = 1'b0;
      end

      // enable cleared: stop at once, drop the pending end-of-cycle copy and disable
      if (!s.en && s.st != ST_IDLE) begin
         next_s.st       = ST_IDLE; // RULE7
         next_s.out_a    = 1'b0;
         next_s.out_b    = 1'b0;
         next_s.sync_eoc = 1'b0;
         next_s.dis_eoc  = 1'b0;
      end

      // blanking trigger: selected edge of the registered outputs
      case (s.blk[BLK_TRIG +: 2])
         2'h0: rise = next_s.out_a & ~s.out_a;
         2'h1: rise = ~next_s.out_a & s.out_a;
         2'h2: rise = next_s.out_b & ~s.out_b;
         default: rise = ~next_s.out_b & s.out_b;
      endcase

      // delay clock tick every 1, 2, 4 or 8 clocks
      div_m1 = 3'((4'h1 << s.blk[BLK_PRE +: 2]) - 4'h1); // RULE13
      if (blank_on && rise) begin
         next_s.brun = 1'b1; // RULE12
         next_s.bcnt = 8'h00;
         next_s.pre  = 3'h0;
      end else if (s.brun) begin
         if (s.pre == div_m1) begin
            next_s.pre = 3'h0;
            if (s.bcnt + 8'h01 >= s.bval) begin
               next_s.brun = 1'b0; // RULE12
            end else begin
               next_s.bcnt = s.bcnt + 8'h01;
            end
         end else begin
            next_s.pre = s.pre + 3'h1;
         end
      end
      if (!blank_on) next_s.brun = 1'b0;

      // read mux; data stands only in the cycle after the strobe
      case (ADDR_I)
         REG_CTRL: rv = DW'(s.en);
         REG_ASET: rv = DW'(s.aset_b);
         REG_ACLR: rv = DW'(s.aclr_b);
         REG_BSET: rv = DW'(s.bset_b);
         REG_BCLR: rv = DW'(s.bclr_b);
         REG_EVA:  rv = DW'(s.eva);
         REG_EVB:  rv = DW'(s.evb);
         REG_BLK:  rv = DW'(s.blk);
         REG_BVAL: rv = DW'(s.bval);
         REG_STAT: rv = DW'({s.st == ST_UP, s.st == ST_HALT, ~busy, s.st != ST_IDLE});
         REG_CNT:  rv = DW'(s.cnt);
         REG_CAPA: rv = DW'(s.cap_a);
         REG_CAPB: rv = DW'(s.cap_b);
         default:  rv = '0;
      endcase
      next_s.rdata = RD_I ? rv : '0;
   end

   // single state register
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s        <= '0;
         s.aset_b <= RST_CMP;
         s.aclr_b <= RST_CMP;
         s.bset_b <= RST_CMP;
         s.bclr_b <= RST_CMP;
         s.eva    <= RST_EV;
         s.evb    <= RST_EV;
         s.st     <= ST_IDLE;
      end else begin
         s <= next_s;
      end
   end

   // synced override is two to three clocks behind the pin, async is direct
   assign WAVE_OUT_A_O = s.out_a & ~kill_sync & ~kill_async; // RULE11 RULE23
   assign WAVE_OUT_B_O = s.out_b & ~kill_sync & ~kill_async; // RULE11 RULE23
   assign RDATA_O      = s.rdata;
endmodule

// ---- dsp_pkg.sv ----
// shared constants and types for the dual-slope waveform timer
package dsp_pkg;
   localparam int AW = 4;
   localparam int DW = 16;
   // register offsets (word index on the plain register port)
   localparam logic [3:0] REG_CTRL  = 4'h0;
   localparam logic [3:0] REG_CMD   = 4'h1;
   localparam logic [3:0] REG_ASET  = 4'h2;
   localparam logic [3:0] REG_ACLR  = 4'h3;
   localparam logic [3:0] REG_BSET  = 4'h4;
   localparam logic [3:0] REG_BCLR  = 4'h5;
   localparam logic [3:0] REG_EVA   = 4'h6;
   localparam logic [3:0] REG_EVB   = 4'h7;
   localparam logic [3:0] REG_BLK   = 4'h8;
   localparam logic [3:0] REG_BVAL  = 4'h9;
   localparam logic [3:0] REG_STAT  = 4'hA;
   localparam logic [3:0] REG_CNT   = 4'hB;
   localparam logic [3:0] REG_CAPA  = 4'hC;
   localparam logic [3:0] REG_CAPB  = 4'hD;
   // command strobe bits
   localparam int CMD_SYNC = 0;
   localparam int CMD_SEOC = 1;
   localparam int CMD_RST  = 2;
   localparam int CMD_CAPA = 3;
   localparam int CMD_CAPB = 4;
   localparam int CMD_DEOC = 5;
   localparam int CMD_W    = 6;
   // event control fields
   localparam int EV_TRIG  = 0;
   localparam int EV_ACT   = 1;
   localparam int EV_FILT  = 2;
   localparam int EV_ASYNC = 3;
   localparam int EV_MODE  = 4;
   // blanking control fields and values
   localparam int BLK_SEL  = 0;
   localparam int BLK_TRIG = 2;
   localparam int BLK_PRE  = 4;
   localparam logic [1:0] BLK_SEL_ON = 2'h1;
   // fault modes acted on in dual-slope operation
   localparam logic [3:0] FM_NONE = 4'h0;
   localparam logic [3:0] FM_KILL = 4'h4;
   localparam logic [3:0] FM_WAIT = 4'h7;
   // reset values
   localparam logic [15:0] RST_CMP = 16'h0000;
   localparam logic [7:0]  RST_EV  = 8'h00;
   // digital filter length in counter clocks
   localparam logic [2:0] FILT_CYC = 3'h4;
   // sequencer states, gray along idle-down-up-halt
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_DOWN = 2'h1,
      ST_UP   = 2'h3,
      ST_HALT = 2'h2
   } dsp_state_t;
endpackage

// ---- dsp_ev_if.sv ----
// carrier between the core and one event input conditioner
`timescale 1ns/10ps
interface dsp_ev_if;
   logic raw;
   logic filt_en;
   logic level;
   modport cond (input raw, input filt_en, output level);
   modport core (output raw, output filt_en, input level);
endinterface

// ---- dsp_ev_cond.sv ----
// event input conditioner: three-flop synchroniser and optional glitch filter
`timescale 1ns/10ps
module dsp_ev_cond
   import dsp_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   dsp_ev_if.cond    ev
);
   typedef struct packed {
      logic [2:0] sy;
      logic       lvl_s;
      logic [2:0] stab;
      logic       lvl;
   } dsp_cond_t;

   dsp_cond_t s;
   dsp_cond_t next_s;
   logic      acc;

   // a change counts once second and third stage agree, else the last level holds
   assign acc = (s.sy[1] == s.sy[2]) ? s.sy[2] : s.lvl_s;

   // filter count restarts whenever the accepted level matches the output again
   always_comb begin
      next_s = s;
      next_s.sy = {s.sy[1:0], ev.raw};
      next_s.lvl_s = acc;
      next_s.stab = 3'h0;
      if (acc != s.lvl) begin
         // short pulses never reach the full count and are dropped
         if (s.stab == FILT_CYC - 3'h1) begin
            next_s.lvl = acc; // RULE15
         end else begin
            next_s.stab = s.stab + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // unfiltered level skips a register so the override lands three clocks after the pin
   assign ev.level = ev.filt_en ? s.lvl : acc; // RULE11
endmodule

// ---- dsp_top_props.sv ----
// concurrent checks on the ports of the waveform timer
`timescale 1ns/10ps
module dsp_top_props
   import dsp_pkg::*;
#(
   parameter int W = 16
)(
   input wire logic          SYS_CLK_I,
   input wire logic          RST_N_I,
   input wire logic [AW-1:0] ADDR_I,
   input wire logic [DW-1:0] WDATA_I,
   input wire logic          WR_I,
   input wire logic          RD_I,
   input wire logic [DW-1:0] RDATA_O,
   input wire logic          EVENT_A_I,
   input wire logic          EVENT_B_I,
   input wire logic          WAVE_OUT_A_O,
   input wire logic          WAVE_OUT_B_O
);
   logic        en_q;
   logic [7:0]  eva_q;
   logic [15:0] bclr_q;
   // shadow of software writes; refusals during a pending sync are not modelled
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         en_q   <= 1'b0;
         eva_q  <= 8'h00;
         bclr_q <= 16'h0000;
      end else if (WR_I) begin
         if (ADDR_I == REG_CTRL) en_q <= WDATA_I[0];
         if (ADDR_I == REG_EVA) eva_q <= WDATA_I[7:0];
         if (ADDR_I == REG_BCLR) bclr_q <= WDATA_I;
      end
   end
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (!RST_N_I);
   // event held long enough to cross the three-flop synchroniser
   sequence s_kill_held;
      (eva_q == 8'h41 && EVENT_A_I)[*6];
   endsequence
   // start from idle with a bottom value large enough for an eight-cycle window
   sequence s_start;
      WR_I && ADDR_I == REG_CTRL && WDATA_I[0] && !en_q && bclr_q > 16'h0008;
   endsequence
   a_rd_idle: assert property (!RD_I |=> RDATA_O == 16'h0000) else $error("read data not zero");
   a_unmapped_zero: assert property (RD_I && ADDR_I > REG_CAPB |=> RDATA_O == 16'h0000) else $error("unmapped read");
   a_bval_width: assert property (RD_I && ADDR_I == REG_BVAL |=> RDATA_O[15:8] == 8'h00) else $error("delay width");
   a_ctrl_echo: assert property ((WR_I && ADDR_I == REG_CTRL) ##1 (RD_I && ADDR_I == REG_CTRL)
      |=> RDATA_O[0] == $past(WDATA_I[0], 2)) else $error("enable readback");
   a_off_quiet: assert property (!en_q [*3] |-> !WAVE_OUT_A_O && !WAVE_OUT_B_O) else $error("output while off");
   a_kill_sync: assert property (s_kill_held |-> !WAVE_OUT_A_O && !WAVE_OUT_B_O) else $error("sync kill late");
   a_kill_async: assert property (eva_q == 8'h49 && EVENT_A_I |-> !WAVE_OUT_A_O && !WAVE_OUT_B_O)
      else $error("async kill late");
   a_b_start_low: assert property (s_start |=> !WAVE_OUT_B_O [*8]) else $error("b set too early");
endmodule

bind dsp_top dsp_top_props #(.W(W)) u_props (
   .SYS_CLK_I(SYS_CLK_I),
   .RST_N_I(RST_N_I),
   .ADDR_I(ADDR_I),
   .WDATA_I(WDATA_I),
   .WR_I(WR_I),
   .RD_I(RD_I),
   .RDATA_O(RDATA_O),
   .EVENT_A_I(EVENT_A_I),
   .EVENT_B_I(EVENT_B_I),
   .WAVE_OUT_A_O(WAVE_OUT_A_O),
   .WAVE_OUT_B_O(WAVE_OUT_B_O)
);

// ---- dsp_ev_src.sv ----
// event routing model driving the two event inputs
`timescale 1ns/10ps
module dsp_ev_src (
   input  wire logic clk_i,
   output logic      ev_a_o = 1'b0,
   output logic      ev_b_o = 1'b0
);
   int left_a = 0;
   int left_b = 0;
   // arm a level pulse; waiting for the falling edge keeps it clear of the sampling edge
   task automatic fire(input bit ch, input int len);
      @(negedge clk_i);
      if (ch) left_b = len;
      else left_a = len;
   endtask
   // each input is a plain level tied to its own output channel
   always @(posedge clk_i) begin
      ev_a_o <= (left_a > 0);
      ev_b_o <= (left_b > 0);
      if (left_a > 0) left_a--;
      if (left_b > 0) left_b--;
   end
endmodule

// ---- dsp_top_tb.sv ----
// self-checking bench for the dual-slope waveform timer
`timescale 1ns/10ps
module dsp_top_tb
   import dsp_pkg::*;
;
   localparam int C = 10;
   logic          clk = 1'b0;
   logic          rst_n = 1'b0;
   logic [AW-1:0] addr = 4'h0;
   logic [DW-1:0] wdata = 16'h0000;
   logic          wr = 1'b0;
   logic          rd = 1'b0;
   logic [DW-1:0] rdata;
   logic          ev_a;
   logic          ev_b;
   logic          wa;
   logic          wb;
   logic [DW-1:0] exp_q[$];
   logic          rd_seen = 1'b0;
   logic [31:0]   seed = 32'h00000038;
   int            mismatches = 0;
   int            checks = 0;
   // pulse table: event control, length, expected output A level late in the pulse
   logic [7:0]    tv [8] = '{8'h40, 8'h01, 8'h43, 8'h41, 8'h45, 8'h45, 8'h49, 8'h41};
   int            tl [8] = '{12, 12, 12, 12, 3, 12, 12, 12};
   logic          te [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};

   dsp_top #(.W(16)) dut (
      .SYS_CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
      .RDATA_O(rdata), .EVENT_A_I(ev_a), .EVENT_B_I(ev_b), .WAVE_OUT_A_O(wa), .WAVE_OUT_B_O(wb)
   );
   dsp_ev_src src (.clk_i(clk), .ev_a_o(ev_a), .ev_b_o(ev_b));

   initial forever #10 clk = ~clk;

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // read data stands only in the cycle after the strobe, so compare there
   always @(posedge clk) begin
      if (rd_seen) chk(rdata, exp_q.pop_front());
      rd_seen <= rd;
   end

   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd <= 1'b0;
   endtask

   // cycles until the chosen output rises, zero when it never did within the limit
   task automatic rise(input bit b, input int lim, output int n);
      logic prev;
      prev = b ? wb : wa;
      for (n = 1; n <= lim; n++) begin
         @(posedge clk);
         if ((b ? wb : wa) === 1'b1 && prev === 1'b0) return;
         prev = b ? wb : wa;
      end
      n = 0;
   endtask

   task automatic meas(input bit b, output int hi, output int per);
      int n;
      rise(b, 60, n);
      hi = 0;
      while ((b ? wb : wa) === 1'b1 && hi < 60) begin
         hi++;
         @(posedge clk);
      end
      rise(b, 60, n);
      per = hi + n;
   endtask

   // hang guard sized well above the twelve hundred or so cycles the sequence needs
   initial begin
      #(20 * 20000);
      mismatches++;
      summarize();
   end

   initial begin
      int hi;
      int per;
      int n;
      logic [DW-1:0] v;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // reset values, then unmapped places
      for (int a = 0; a < 14; a++) if (a != 1) rd_reg(4'(a), a == 10 ? 16'h0002 : 16'h0000);
      rd_reg(4'hE, 16'h0000);
      rd_reg(4'hF, 16'h0000);
      // buffered compares and delay value read back while idle
      for (int a = 2; a < 10; a++) begin
         v = (a == 9) ? {8'h00, 8'(xs())} : 16'(xs());
         if (a < 6 || a == 9) wr_reg(4'(a), v);
         if (a < 6 || a == 9) rd_reg(4'(a), v);
      end
      wr_reg(REG_ASET, 16'h0006);
      wr_reg(REG_BSET, 16'h0003);
      wr_reg(REG_BCLR, 16'(C));
      // enable write and its read-back in adjacent cycles, no idle gap between strobes
      @(posedge clk);
      addr <= REG_CTRL;
      wdata <= 16'h0001;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      exp_q.push_back(16'h0001);
      @(posedge clk);
      rd <= 1'b0;
      rise(1, 40, n);
      chk(16'(n >= C), 16'h0001);
      meas(1, hi, per);
      chk(16'(hi), 16'h000F);
      meas(0, hi, per);
      chk(16'(hi), 16'h000D);
      chk(16'(per), 16'(2 * (C + 1)));
      rise(0, 40, n);
      chk({15'h0000, wb}, 16'h0001);
      // event pulses launched just after A rises, A looked at eleven cycles on
      for (int i = 0; i < 8; i++) begin
         wr_reg(i == 7 ? REG_EVB : REG_EVA, {8'h00, tv[i]});
         rise(0, 40, n);
         src.fire(i == 7, tl[i]);
         repeat (11) @(posedge clk);
         chk({15'h0000, wa}, {15'h0000, te[i]});
         repeat (30) @(posedge clk);
         wr_reg(i == 7 ? REG_EVB : REG_EVA, 16'h0000);
      end
      // blanking from the A rise masks a filtered A kill for ten ticks of two clocks
      wr_reg(REG_BVAL, 16'h000A);
      wr_reg(REG_BLK, 16'h0011);
      wr_reg(REG_EVA, 16'h0045);
      rise(0, 40, n);
      src.fire(0, 12);
      repeat (11) @(posedge clk);
      chk({15'h0000, wa}, 16'h0001);
      repeat (30) @(posedge clk);
      wr_reg(REG_EVA, 16'h0000);
      wr_reg(REG_BLK, 16'h0000);
      // halting fault: stays halted, restart while active halts again, then resumes
      wr_reg(REG_EVA, 16'h0071);
      src.fire(0, 40);
      repeat (10) @(posedge clk);
      rise(0, 25, n);
      chk(16'(n), 16'h0000);
      wr_reg(REG_CMD, 16'h0004);
      rise(0, 25, n);
      chk(16'(n), 16'h0000);
      wr_reg(REG_CMD, 16'h0004);
      rise(0, 30, n);
      chk(16'(n > 0), 16'h0001);
      wr_reg(REG_EVA, 16'h0000);
      // immediate and end-of-cycle compare transfer; the A-clear value is ignored
      wr_reg(REG_ASET, 16'h0004);
      wr_reg(REG_ACLR, 16'(xs()));
      wr_reg(REG_CMD, 16'h0001);
      meas(0, hi, per);
      meas(0, hi, per);
      chk(16'(hi), 16'h0009);
      chk(16'(per), 16'(2 * (C + 1)));
      wr_reg(REG_ASET, 16'h0002);
      wr_reg(REG_CMD, 16'h0002);
      meas(0, hi, per);
      meas(0, hi, per);
      chk(16'(hi), 16'h0005);
      // disable at cycle end keeps the current cycle going
      rise(0, 30, n);
      wr_reg(REG_CMD, 16'h0020);
      chk({15'h0000, wa}, 16'h0001);
      repeat (30) @(posedge clk);
      rd_reg(REG_CTRL, 16'h0000);
      // clearing enable stops at once; soft captures taken one step into the first down-count
      wr_reg(REG_CTRL, 16'h0001);
      wr_reg(REG_CMD, 16'h0018);
      rd_reg(REG_CAPA, 16'(C - 1));
      rd_reg(REG_CAPB, 16'(C - 1));
      rd_reg(REG_CTRL, 16'h0001);
      rise(0, 30, n);
      wr_reg(REG_CTRL, 16'h0000);
      repeat (2) @(posedge clk);
      chk({15'h0000, wa}, 16'h0000);
      repeat (5) @(posedge clk);
      summarize();
   end
endmodule
